// [include/alu_defines.svh]
// Constants for the increment, OR and logical shift datapath
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

// ************************************************************
// Widths and depth
// ************************************************************
`define ALU_DATA_W 8
`define ALU_ADDR_W 7
`define ALU_FILE_DEPTH 128

// ************************************************************
// Reset values
// ************************************************************
`define ALU_ACCUM_RST 8'h00
`define ALU_RESULT_RST 8'h00
`define ALU_FLAG_RST 1'b0
`define ALU_PULSE_RST 1'b0

// ************************************************************
// Destination select encoding
// ************************************************************
`define ALU_DEST_ACCUM 1'b0
`define ALU_DEST_FILE 1'b1

// ************************************************************
// Shift fill value and increment step
// ************************************************************
`define ALU_SHIFT_FILL 1'b0
`define ALU_INC_STEP 1'b1

`endif

// [include/alu_pkg.sv]
// Types shared by the datapath control and execution modules
package alu_pkg;

    // Operation codes presented on the operation port
    typedef enum logic [2:0] {
        NO_OP = 3'h0,
        INCREMENT_REGISTER_OP = 3'h1,
        INCREMENT_SKIP_ZERO_OP = 3'h2,
        OR_LITERAL_ACCUM_OP = 3'h3,
        OR_ACCUM_REGISTER_OP = 3'h4,
        SHIFT_LEFT_LOGICAL_OP = 3'h5,
        SHIFT_RIGHT_LOGICAL_OP = 3'h6
    } op_code_e;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_SKIP = 2'b10
    } seq_state_e;

endpackage : alu_pkg

// [include/alu_exec_if.sv]
// Interface between the sequencer and the execution unit
`timescale 1ns/10ps
`default_nettype none

interface alu_exec_if
    import alu_pkg::*;
#(
    parameter int DATA_W = 8
);
    op_code_e op;
    logic dest;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] accum;
    logic [DATA_W-1:0] literal;
    logic [DATA_W-1:0] result;
    logic wr_accum;
    logic wr_file;
    logic zero_upd;
    logic zero_val;
    logic carry_upd;
    logic carry_val;
    logic skip_req;
    logic illegal;

    // Sequencer side drives operands, reads results
    modport ctrl (
        output op, dest, operand, accum, literal,
        input result, wr_accum, wr_file, zero_upd, zero_val,
        input carry_upd, carry_val, skip_req, illegal
    );

    // Execution unit side
    modport core (
        input op, dest, operand, accum, literal,
        output result, wr_accum, wr_file, zero_upd, zero_val,
        output carry_upd, carry_val, skip_req, illegal
    );
endinterface : alu_exec_if

`default_nettype wire

// [hw/alu_exec.sv]
// Combinational execution unit for the six byte operations
`timescale 1ns/10ps
`default_nettype none
`include "alu_defines.svh"

module alu_exec
    import alu_pkg::*;
#(
    parameter int DATA_W = `ALU_DATA_W
) (
    alu_exec_if.core bus
);

    logic [DATA_W:0] inc_sum;
    logic [DATA_W-1:0] zero_word;

    // ************************************************************
    // Increment, wrapping modulo two to the data width
    // ************************************************************
    assign zero_word = '0;
    assign inc_sum = {1'b0, bus.operand} + {{DATA_W{1'b0}}, `ALU_INC_STEP}; // RQ12

    // ************************************************************
    // Operation select
    // ************************************************************
    // Defaults leave every flag alone and write nothing
    always_comb begin
        bus.result = bus.operand;
        bus.wr_accum = 1'b0;
        bus.wr_file = 1'b0;
        bus.zero_upd = 1'b0;
        bus.carry_upd = 1'b0;
        bus.carry_val = `ALU_FLAG_RST;
        bus.skip_req = 1'b0;
        bus.illegal = 1'b0;
        unique case (bus.op)
            NO_OP: begin
                bus.result = bus.accum;
            end
            INCREMENT_REGISTER_OP: begin
                bus.result = inc_sum[DATA_W-1:0]; // RQ1
                bus.wr_accum = (bus.dest == `ALU_DEST_ACCUM); // RQ1
                bus.wr_file = (bus.dest == `ALU_DEST_FILE); // RQ1
                bus.zero_upd = 1'b1; // RQ2
            end
            INCREMENT_SKIP_ZERO_OP: begin
                // Flags are deliberately untouched here
                bus.result = inc_sum[DATA_W-1:0]; // RQ3
                bus.wr_accum = (bus.dest == `ALU_DEST_ACCUM); // RQ3
                bus.wr_file = (bus.dest == `ALU_DEST_FILE); // RQ3
                bus.skip_req = (inc_sum[DATA_W-1:0] == zero_word); // RQ3
                bus.zero_upd = 1'b0; // RQ4
            end
            OR_LITERAL_ACCUM_OP: begin
                // Destination select does not apply to the literal form
                bus.result = bus.accum | bus.literal; // RQ5
                bus.wr_accum = 1'b1; // RQ5
                bus.zero_upd = 1'b1; // RQ2
            end
            OR_ACCUM_REGISTER_OP: begin
                bus.result = bus.accum | bus.operand; // RQ6
                bus.wr_accum = (bus.dest == `ALU_DEST_ACCUM); // RQ6
                bus.wr_file = (bus.dest == `ALU_DEST_FILE); // RQ6
                bus.zero_upd = 1'b1; // RQ2
            end
            SHIFT_LEFT_LOGICAL_OP: begin
                bus.result = {bus.operand[DATA_W-2:0], `ALU_SHIFT_FILL}; // RQ7
                bus.wr_accum = (bus.dest == `ALU_DEST_ACCUM); // RQ7
                bus.wr_file = (bus.dest == `ALU_DEST_FILE); // RQ7
                bus.carry_upd = 1'b1; // RQ11
                bus.carry_val = bus.operand[DATA_W-1]; // RQ9
                bus.zero_upd = 1'b1; // RQ11
            end
            SHIFT_RIGHT_LOGICAL_OP: begin
                bus.result = {`ALU_SHIFT_FILL, bus.operand[DATA_W-1:1]}; // RQ8
                bus.wr_accum = (bus.dest == `ALU_DEST_ACCUM); // RQ8
                bus.wr_file = (bus.dest == `ALU_DEST_FILE); // RQ8
                bus.carry_upd = 1'b1; // RQ11
                bus.carry_val = bus.operand[0]; // RQ10
                bus.zero_upd = 1'b1; // RQ11
            end
            default: begin
                // Unused code: executes as a no-operation
                bus.result = bus.accum;
                bus.illegal = 1'b1;
            end
        endcase
    end

    // Zero test on whatever result was chosen
    assign bus.zero_val = (bus.result == zero_word); // RQ2 RQ11

endmodule : alu_exec

`default_nettype wire

// [hw/alu_datapath.sv]
// Top of the increment, OR and logical shift datapath with its register file
//
// What this block does
// [RQ1] Increment register; destination bit picks target
// [RQ2] Increment register and OR forms update zero only
// [RQ3] Increment-skip squashes next instruction on zero
// [RQ4] Increment-skip leaves all flags unchanged
// [RQ5] OR eight-bit literal into accumulator
// [RQ6] OR accumulator with register; destination selectable
// [RQ7] Left shift, zero into bit zero
// [RQ8] Right shift, zero into top bit
// [RQ9] Left shift loads carry from top bit
// [RQ10] Right shift loads carry from bit zero
// [RQ11] Shifts update carry and zero flags
// [RQ12] Seven-bit register address; increment wraps
`timescale 1ns/10ps
`default_nettype none
`include "alu_defines.svh"

module alu_datapath
    import alu_pkg::*;
#(
    parameter int DATA_W = `ALU_DATA_W,
    parameter int ADDR_W = `ALU_ADDR_W,
    parameter int FILE_DEPTH = `ALU_FILE_DEPTH
) (
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    // Operation port
    input wire logic OP_VALID_IN,
    input wire logic [2:0] OP_CODE_IN,
    input wire logic [ADDR_W-1:0] OP_ADDR_IN,
    input wire logic OP_DEST_IN,
    input wire logic [DATA_W-1:0] OP_LITERAL_IN,
    // Side access to the register file
    input wire logic FILE_WR_EN_IN,
    input wire logic [ADDR_W-1:0] FILE_WR_ADDR_IN,
    input wire logic [DATA_W-1:0] FILE_WR_DATA_IN,
    input wire logic [ADDR_W-1:0] FILE_RD_ADDR_IN,
    output logic [DATA_W-1:0] FILE_RD_DATA_OUT,
    // Results and status
    output logic OP_DONE_OUT,
    output logic OP_SQUASHED_OUT,
    output logic OP_ILLEGAL_OUT,
    output logic SKIP_PENDING_OUT,
    output logic FILE_WR_DROPPED_OUT,
    output logic [DATA_W-1:0] RESULT_OUT,
    output logic [DATA_W-1:0] ACCUM_OUT,
    output logic ZERO_FLAG_OUT,
    output logic CARRY_FLAG_OUT
);

    // ************************************************************
    // Storage and state
    // ************************************************************
    // Data registers; not reset, software initialises them
    logic [DATA_W-1:0] file_mem_q [FILE_DEPTH];

    seq_state_e state_q;
    seq_state_e state_d;
    logic [DATA_W-1:0] accum_q;
    logic zero_q;
    logic carry_q;
    logic done_q;
    logic squash_q;
    logic illegal_q;
    logic skip_pend_q;
    logic wr_drop_q;
    logic [DATA_W-1:0] result_q;
    logic [DATA_W-1:0] rd_data_q;

    // Qualified strobes
    logic exec;
    logic squash;
    logic file_wr;
    logic host_wr;
    logic [DATA_W-1:0] operand;

    alu_exec_if #(.DATA_W(DATA_W)) ex_bus ();

    // ************************************************************
    // Operation acceptance
    // ************************************************************
    // An operation offered while a skip is pending is the skipped one
    assign exec = OP_VALID_IN && (state_q == ST_EXEC);
    assign squash = OP_VALID_IN && (state_q == ST_SKIP); // RQ3

    // Register operand read, address covers the whole file
    assign operand = file_mem_q[OP_ADDR_IN]; // RQ12

    // ************************************************************
    // Execution unit
    // ************************************************************
    // Unknown codes are passed through; the unit flags them
    assign ex_bus.op = op_code_e'(OP_CODE_IN);
    assign ex_bus.dest = OP_DEST_IN;
    assign ex_bus.operand = operand;
    assign ex_bus.accum = accum_q;
    assign ex_bus.literal = OP_LITERAL_IN;

    alu_exec #(
        .DATA_W(DATA_W)
    ) u_exec (
        .bus(ex_bus.core)
    );

    // ************************************************************
    // Skip sequencer
    // ************************************************************
    // Next state: a zero result of increment-skip arms the skip,
    // and the next offered operation consumes it as a no-operation
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_EXEC: begin
                if (exec && ex_bus.skip_req) begin
                    state_d = ST_SKIP; // RQ3
                end
            end
            ST_SKIP: begin
                if (OP_VALID_IN) begin
                    state_d = ST_EXEC; // RQ3
                end
            end
            default: begin
                state_d = ST_EXEC;
            end
        endcase
    end

    // State register
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            state_q <= ST_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // Skip pending shown from its own flop for a clean output
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            skip_pend_q <= `ALU_PULSE_RST;
        end else begin
            skip_pend_q <= (state_d == ST_SKIP);
        end
    end

    // ************************************************************
    // Accumulator
    // ************************************************************
    // A squashed operation must not touch the accumulator
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            accum_q <= `ALU_ACCUM_RST;
        end else if (exec && ex_bus.wr_accum) begin
            accum_q <= ex_bus.result; // RQ1 RQ5 RQ6
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    // Zero flag: increment-skip never asserts zero_upd
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            zero_q <= `ALU_FLAG_RST;
        end else if (exec && ex_bus.zero_upd) begin
            zero_q <= ex_bus.zero_val; // RQ2 RQ4 RQ11
        end
    end

    // Carry flag: only the two shifts load it
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            carry_q <= `ALU_FLAG_RST;
        end else if (exec && ex_bus.carry_upd) begin
            carry_q <= ex_bus.carry_val; // RQ9 RQ10 RQ11
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    // The operation has the write port first; a side write in the
    // same cycle is dropped rather than queued, keeping one port
    assign file_wr = exec && ex_bus.wr_file;
    assign host_wr = FILE_WR_EN_IN && !file_wr;

    always_ff @(posedge SYS_CLK_IN) begin
        if (file_wr) begin
            file_mem_q[OP_ADDR_IN] <= ex_bus.result; // RQ1 RQ6 RQ7 RQ8
        end else if (host_wr) begin
            file_mem_q[FILE_WR_ADDR_IN] <= FILE_WR_DATA_IN;
        end
    end

    // Registered side read; shows the contents before this edge
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            rd_data_q <= `ALU_RESULT_RST;
        end else begin
            rd_data_q <= file_mem_q[FILE_RD_ADDR_IN];
        end
    end

    // Side write lost to an operation write
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            wr_drop_q <= `ALU_PULSE_RST;
        end else begin
            wr_drop_q <= FILE_WR_EN_IN && file_wr;
        end
    end

    // ************************************************************
    // Completion pulses and result
    // ************************************************************
    // Done pulses for executed and squashed operations alike
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            done_q <= `ALU_PULSE_RST;
            squash_q <= `ALU_PULSE_RST;
            illegal_q <= `ALU_PULSE_RST;
        end else begin
            done_q <= exec || squash;
            squash_q <= squash; // RQ3
            illegal_q <= exec && ex_bus.illegal;
        end
    end

    // Result of the last executed operation, whatever its target
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            result_q <= `ALU_RESULT_RST;
        end else if (exec) begin
            result_q <= ex_bus.result;
        end
    end

    // ************************************************************
    // Outputs, all straight from flops
    // ************************************************************
    assign FILE_RD_DATA_OUT = rd_data_q;
    assign OP_DONE_OUT = done_q;
    assign OP_SQUASHED_OUT = squash_q;
    assign OP_ILLEGAL_OUT = illegal_q;
    assign SKIP_PENDING_OUT = skip_pend_q;
    assign FILE_WR_DROPPED_OUT = wr_drop_q;
    assign RESULT_OUT = result_q;
    assign ACCUM_OUT = accum_q;
    assign ZERO_FLAG_OUT = zero_q;
    assign CARRY_FLAG_OUT = carry_q;

endmodule : alu_datapath

`default_nettype wire

// [verification/alu_datapath_sva.sv]
// Port-level assertions for the increment, OR and logical shift datapath
`timescale 1ns/10ps
`default_nettype none

module alu_datapath_sva
    import alu_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    input wire logic OP_VALID_IN,
    input wire logic [2:0] OP_CODE_IN,
    input wire logic OP_DEST_IN,
    input wire logic [DATA_W-1:0] OP_LITERAL_IN,
    input wire logic OP_DONE_OUT,
    input wire logic OP_SQUASHED_OUT,
    input wire logic SKIP_PENDING_OUT,
    input wire logic [DATA_W-1:0] RESULT_OUT,
    input wire logic [DATA_W-1:0] ACCUM_OUT,
    input wire logic ZERO_FLAG_OUT,
    input wire logic CARRY_FLAG_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff SRST_IN;

    // ******************************************************
    // Helper terms
    // ******************************************************
    // An offered op only executes when no skip is armed
    logic exec;
    logic reg_form;
    assign exec = OP_VALID_IN && !SKIP_PENDING_OUT;
    assign reg_form = exec && (OP_CODE_IN inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6});

    // ******************************************************
    // Properties
    // ******************************************************
    chk_done_next: assert property (OP_VALID_IN |=> OP_DONE_OUT)
        else $error("done pulse missing after an offered operation");
    chk_or_lit_value: assert property (exec && OP_CODE_IN == OR_LITERAL_ACCUM_OP |=>
        ACCUM_OUT == ($past(ACCUM_OUT) | $past(OP_LITERAL_IN)))
        else $error("literal OR result wrong");
    chk_or_lit_flags: assert property (exec && OP_CODE_IN == OR_LITERAL_ACCUM_OP |=>
        ZERO_FLAG_OUT == (ACCUM_OUT == '0) && $stable(CARRY_FLAG_OUT))
        else $error("literal OR flags wrong");
    chk_skip_flags: assert property (exec && OP_CODE_IN == INCREMENT_SKIP_ZERO_OP |=>
        $stable(ZERO_FLAG_OUT) && $stable(CARRY_FLAG_OUT))
        else $error("increment-skip changed a flag");
    chk_skip_arm: assert property (exec && OP_CODE_IN == INCREMENT_SKIP_ZERO_OP |=>
        SKIP_PENDING_OUT == (RESULT_OUT == '0))
        else $error("skip armed wrongly");
    chk_squash_op: assert property (OP_VALID_IN && SKIP_PENDING_OUT |=>
        OP_SQUASHED_OUT && !SKIP_PENDING_OUT && $stable(ACCUM_OUT))
        else $error("squashed op not a no-op");
    chk_shl_fill: assert property (exec && OP_CODE_IN == SHIFT_LEFT_LOGICAL_OP |=>
        !RESULT_OUT[0] && ZERO_FLAG_OUT == (RESULT_OUT == '0))
        else $error("left shift fill or zero wrong");
    chk_shr_fill: assert property (exec && OP_CODE_IN == SHIFT_RIGHT_LOGICAL_OP |=>
        !RESULT_OUT[DATA_W-1] && ZERO_FLAG_OUT == (RESULT_OUT == '0))
        else $error("right shift fill or zero wrong");
    chk_dest_file: assert property (reg_form && OP_DEST_IN |=> $stable(ACCUM_OUT))
        else $error("register destination touched accumulator");
    chk_dest_accum: assert property (reg_form && !OP_DEST_IN |=> ACCUM_OUT == RESULT_OUT)
        else $error("accumulator destination not written");
endmodule : alu_datapath_sva

bind alu_datapath alu_datapath_sva #(.DATA_W(DATA_W)) i_alu_datapath_sva (
    .SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN), .OP_VALID_IN(OP_VALID_IN),
    .OP_CODE_IN(OP_CODE_IN), .OP_DEST_IN(OP_DEST_IN), .OP_LITERAL_IN(OP_LITERAL_IN),
    .OP_DONE_OUT(OP_DONE_OUT), .OP_SQUASHED_OUT(OP_SQUASHED_OUT),
    .SKIP_PENDING_OUT(SKIP_PENDING_OUT), .RESULT_OUT(RESULT_OUT), .ACCUM_OUT(ACCUM_OUT),
    .ZERO_FLAG_OUT(ZERO_FLAG_OUT), .CARRY_FLAG_OUT(CARRY_FLAG_OUT)
);

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the increment, OR and logical shift datapath
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import alu_pkg::*;
;
    logic sys_clk, srst, op_valid, op_dest, file_wr_en;
    logic [2:0] op_code;
    logic [6:0] op_addr, file_wr_addr, file_rd_addr;
    logic [7:0] op_literal, file_wr_data, file_rd_data, result, accum;
    logic op_done, op_squashed, op_illegal, skip_pending, zero, carry, wr_dropped;
    // Shadow of the expected state, kept apart from the design
    logic [7:0] mem_m [128];
    logic [7:0] acc_m;
    logic z_m, c_m, skip_m;
    int failures, n_checks;

    alu_datapath i_alu_datapath (
        .SYS_CLK_IN(sys_clk), .SRST_IN(srst), .OP_VALID_IN(op_valid), .OP_CODE_IN(op_code),
        .OP_ADDR_IN(op_addr), .OP_DEST_IN(op_dest), .OP_LITERAL_IN(op_literal),
        .FILE_WR_EN_IN(file_wr_en), .FILE_WR_ADDR_IN(file_wr_addr),
        .FILE_WR_DATA_IN(file_wr_data), .FILE_RD_ADDR_IN(file_rd_addr),
        .FILE_RD_DATA_OUT(file_rd_data), .OP_DONE_OUT(op_done),
        .OP_SQUASHED_OUT(op_squashed), .OP_ILLEGAL_OUT(op_illegal),
        .SKIP_PENDING_OUT(skip_pending), .FILE_WR_DROPPED_OUT(wr_dropped), .RESULT_OUT(result),
        .ACCUM_OUT(accum), .ZERO_FLAG_OUT(zero), .CARRY_FLAG_OUT(carry)
    );

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    // ******************************************************
    // Shared helpers
    // ******************************************************
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask : chk

    // Preload a register through the side port; entered at a falling edge
    task automatic wr_file(input logic [6:0] a, input logic [7:0] v);
        file_wr_en = 1'b1;
        file_wr_addr = a;
        file_wr_data = v;
        @(negedge sys_clk);
        file_wr_en = 1'b0;
        mem_m[a] = v;
    endtask : wr_file

    // One operation: predict, drive for one cycle, compare, then read the register back
    task automatic run(input logic [2:0] code, input logic [6:0] a, input logic d,
                       input logic [7:0] k);
        logic [7:0] src;
        logic [7:0] res;
        logic squash;
        logic reg_form;
        src = mem_m[a];
        squash = skip_m;
        reg_form = code inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
        case (code)
            3'h1, 3'h2: res = src + 8'h01;
            3'h3: res = acc_m | k;
            3'h4: res = acc_m | src;
            3'h5: res = {src[6:0], 1'b0};
            3'h6: res = {1'b0, src[7:1]};
            default: res = 8'h00;
        endcase
        if (squash) begin
            skip_m = 1'b0;
        end else begin
            if (reg_form && code != 3'h2 || code == 3'h3) z_m = (res == 8'h00);
            if (code == 3'h5) c_m = src[7];
            if (code == 3'h6) c_m = src[0];
            if (code == 3'h2) skip_m = (res == 8'h00);
            if (code == 3'h3 || reg_form && !d) acc_m = res;
            else if (reg_form) mem_m[a] = res;
        end
        op_valid = 1'b1;
        op_code = code;
        op_addr = a;
        op_dest = d;
        op_literal = k;
        @(negedge sys_clk);
        op_valid = 1'b0;
        chk("done", 8'h01, {7'h00, op_done});
        chk("squashed", {7'h00, squash}, {7'h00, op_squashed});
        chk("illegal", {7'h00, (!squash && code == 3'h7)}, {7'h00, op_illegal});
        chk("skip_pending", {7'h00, skip_m}, {7'h00, skip_pending});
        chk("accum", acc_m, accum);
        chk("zero", {7'h00, z_m}, {7'h00, zero});
        chk("carry", {7'h00, c_m}, {7'h00, carry});
        if (!squash && (reg_form || code == 3'h3)) chk("result", res, result);
        file_rd_addr = a;
        @(negedge sys_clk);
        chk("file", mem_m[a], file_rd_data);
    endtask : run

    // ******************************************************
    // Scenarios
    // ******************************************************
    task automatic t_reset_values();
        chk("accum", 8'h00, accum);
        chk("result", 8'h00, result);
        chk("flags", 8'h00, {6'h00, zero, carry});
        chk("skip_pending", 8'h00, {7'h00, skip_pending});
    endtask : t_reset_values

    // Both ends of each shift; the last leaves carry set for later
    task automatic t_shifts();
        wr_file(7'h10, 8'h81);
        run(3'h5, 7'h10, 1'b0, 8'h00);
        wr_file(7'h11, 8'h80);
        run(3'h5, 7'h11, 1'b1, 8'h00);
        wr_file(7'h12, 8'hFE);
        run(3'h6, 7'h12, 1'b1, 8'h00);
        wr_file(7'h13, 8'h01);
        run(3'h6, 7'h13, 1'b0, 8'h00);
    endtask : t_shifts

    // Carry must survive; the register at the top address wraps from FF to 00
    task automatic t_increment();
        wr_file(7'h05, 8'h7F);
        run(3'h1, 7'h05, 1'b0, 8'h00);
        wr_file(7'h7F, 8'hFF);
        run(3'h1, 7'h7F, 1'b1, 8'h00);
    endtask : t_increment

    // Skip held across the read-back idle cycle, then squashes the next op
    task automatic t_skip();
        wr_file(7'h04, 8'h01);
        run(3'h2, 7'h04, 1'b0, 8'h00);
        run(3'h3, 7'h04, 1'b0, 8'h00);
        wr_file(7'h03, 8'hFF);
        run(3'h2, 7'h03, 1'b1, 8'h00);
        run(3'h3, 7'h03, 1'b0, 8'h0F);
        wr_file(7'h06, 8'hFF);
        run(3'h2, 7'h06, 1'b0, 8'h00);
        run(3'h5, 7'h06, 1'b0, 8'h00);
    endtask : t_skip

    task automatic t_or();
        wr_file(7'h09, 8'h30);
        run(3'h3, 7'h09, 1'b1, 8'h05);
        run(3'h4, 7'h09, 1'b1, 8'h00);
        run(3'h4, 7'h09, 1'b0, 8'h00);
        wr_file(7'h0A, 8'h01);
        run(3'h6, 7'h0A, 1'b0, 8'h00);
        run(3'h3, 7'h0A, 1'b0, 8'h00);
        run(3'h3, 7'h0A, 1'b0, 8'hFF);
    endtask : t_or

    // Illegal and explicit no-op codes change nothing
    task automatic t_other();
        run(3'h7, 7'h09, 1'b0, 8'h00);
        run(3'h0, 7'h09, 1'b1, 8'h00);
    endtask : t_other

    // Side write in the same cycle as a register-destination op is lost
    task automatic t_drop();
        wr_file(7'h21, 8'h55);
        wr_file(7'h20, 8'h10);
        file_wr_en = 1'b1;
        file_wr_addr = 7'h21;
        file_wr_data = 8'hAA;
        op_valid = 1'b1;
        op_code = 3'h1;
        op_addr = 7'h20;
        op_dest = 1'b1;
        @(negedge sys_clk);
        op_valid = 1'b0;
        file_wr_en = 1'b0;
        mem_m[7'h20] = 8'h11;
        z_m = 1'b0;
        chk("dropped", 8'h01, {7'h00, wr_dropped});
        chk("zero", {7'h00, z_m}, {7'h00, zero});
        chk("accum", acc_m, accum);
        file_rd_addr = 7'h21;
        @(negedge sys_clk);
        chk("dropped", 8'h00, {7'h00, wr_dropped});
        chk("file", 8'h55, file_rd_data);
        file_rd_addr = 7'h20;
        @(negedge sys_clk);
        chk("file", mem_m[7'h20], file_rd_data);
    endtask : t_drop

    // Reset in mid-run clears an armed skip and the flags, not the file
    task automatic t_mid_reset();
        wr_file(7'h30, 8'hFF);
        run(3'h2, 7'h30, 1'b0, 8'h00);
        srst = 1'b1;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        {acc_m, z_m, c_m, skip_m} = '0;
        t_reset_values();
        wr_file(7'h31, 8'h04);
        run(3'h6, 7'h31, 1'b0, 8'h00);
    endtask : t_mid_reset

    // ******************************************************
    // Sequence and verdict
    // ******************************************************
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        {sys_clk, op_valid, op_dest, file_wr_en, op_code} = '0;
        {op_addr, file_wr_addr, file_rd_addr, op_literal, file_wr_data} = '0;
        {acc_m, z_m, c_m, skip_m} = '0;
        srst = 1'b1;
        failures = 0;
        n_checks = 0;
        repeat (20) @(negedge sys_clk);
        srst = 1'b0;
        t_reset_values();
        t_shifts();
        t_increment();
        t_skip();
        t_or();
        t_other();
        t_drop();
        t_mid_reset();
        end_sim();
    end

    // Guard against a hang
    initial begin
        repeat (5000) @(posedge sys_clk);
        $display("MISMATCH run_time expected finish seen timeout");
        failures++;
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
